// [etw_pkg.sv]
// Constants and types of the two-wire serial EEPROM client link.
// Assumes a 100 MHz system clock sampling the bus lines.
// How it works
// - Held in reset until power-on threshold crossed, then enters standby.
// - Data sampled on clock rise; device changes its output after clock fall.
// - Bytes shift most significant bit first, one bit per clock.
// - Each byte takes nine clocks: eight data plus acknowledge.
// - Data changes only while clock low; change while high is Start/Stop.
// - Data falling while clock high is Start and wakes from standby.
// - Device watches lines always and responds only after Start.
// - Data rising while clock high is Stop; ends transfer, back to standby.
// - Repeated Start is accepted as beginning of a new command.
// - No limit on bytes between Start and Stop.
// - Bus idle only when clock and data both high.
// - Transmitter releases data after eighth bit; receiver holds low ninth.
// - Receiver releases data line at end of ninth clock.
// - Host not-acknowledge ends read; device releases line for Stop.
// - Standby after power-up, Stop without write, or write completion.
// - Clocked after interruption, device eventually stops driving data.
// - Acknowledge address byte only on own address, else ignore transfer.
// - No address acknowledge while internal write cycle runs.
package etw_pkg;
  localparam int ETW_SYS_CLK_MHZ = 100;
  localparam int ETW_PUP_WAIT_US = 100;
  localparam int ETW_PUP_WAIT_CYC = ETW_PUP_WAIT_US * ETW_SYS_CLK_MHZ;
  localparam int ETW_BITS_PER_BYTE = 8;
  localparam int ETW_ACK_BIT_IDX = 8;
  localparam int ETW_DEV_TYPE_LSB = 4;
  // Arbitrary device type code; each product sets its own
  localparam logic [3:0] ETW_DEV_TYPE_RST = 4'h5;
  localparam logic [3:0] ETW_BIT_CNT_RST = 4'h0;
  localparam logic [7:0] ETW_BYTE_RST = 8'h00;
  typedef enum logic [4:0] {
    ETW_ST_RESET = 5'b00001,
    ETW_ST_STANDBY = 5'b00010,
    ETW_ST_ADDR = 5'b00100,
    ETW_ST_RX = 5'b01000,
    ETW_ST_TX = 5'b10000
  } etw_state_t;
endpackage

// [etw_sync.sv]
// Two-flop synchroniser for bus lines coming from another clock domain.
// Assumes inputs are asynchronous to clk_sys_in.
`timescale 1ns/1ns
`default_nettype none
module etw_sync #(
  parameter int WIDTH = 2,
  parameter logic [WIDTH-1:0] RST_VAL = '1
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // Lines
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_ff;
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      meta_ff <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_ff <= async_in;
      sync_out <= meta_ff;
    end
  end
endmodule
`default_nettype wire

// [etw_edges.sv]
// Finds edges of clock and data and Start/Stop from synchronised samples.
// Assumes synchronised inputs on clk_sys_in.
`timescale 1ns/1ns
`default_nettype none
module etw_edges (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // Synchronised lines
  input wire logic scl_in,
  input wire logic sda_in,
  // Events
  output logic scl_rise_out,
  output logic scl_fall_out,
  output logic start_out,
  output logic stop_out,
  output logic idle_out
);
  logic scl_prev_ff;
  logic sda_prev_ff;
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      scl_prev_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
      scl_rise_out <= 1'b0;
      scl_fall_out <= 1'b0;
      start_out <= 1'b0;
      stop_out <= 1'b0;
      idle_out <= 1'b1;
    end else begin
      scl_prev_ff <= scl_in;
      sda_prev_ff <= sda_in;
      scl_rise_out <= scl_in & ~scl_prev_ff;
      scl_fall_out <= ~scl_in & scl_prev_ff;
      start_out <= scl_in & scl_prev_ff & sda_prev_ff & ~sda_in;
      stop_out <= scl_in & scl_prev_ff & ~sda_prev_ff & sda_in;
      idle_out <= scl_in & sda_in;
    end
  end
endmodule
`default_nettype wire

// [etw_client.sv]
// Two-wire serial EEPROM client: framing, acknowledge, standby, recovery.
// Assumes the host drives the serial clock; memory access lives elsewhere.
`timescale 1ns/1ns
`default_nettype none
module etw_client
  import etw_pkg::*;
#(
  parameter int PUP_WAIT_CYC = etw_pkg::ETW_PUP_WAIT_CYC,
  parameter logic [3:0] DEV_TYPE = etw_pkg::ETW_DEV_TYPE_RST
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // Power-on detector
  input wire logic power_good_in,
  // Bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  // Straps
  input wire logic [2:0] strap_address_inputs_in,
  // Memory side
  input wire logic write_busy_in,
  input wire logic write_done_in,
  input wire logic [7:0] tx_data_in,
  output logic tx_req_out,
  output logic [7:0] rx_data_out,
  output logic rx_valid_out,
  output logic [7:0] addr_byte_out,
  output logic addr_valid_out,
  output logic stop_seen_out,
  output logic standby_out,
  output logic ready_out
);
  import etw_pkg::*;

  // Elaboration refuses a wait the counter cannot express
  if (PUP_WAIT_CYC < 1) begin : g_bad_wait
    $error("PUP_WAIT_CYC must be at least one");
  end

  logic [1:0] lines_sync;
  logic pwr_good_s;
  logic [2:0] strap_s;
  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  logic idle_s;

  etw_sync #(.WIDTH(2), .RST_VAL(2'h3)) u_line_sync (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .async_in({scl_in, sda_in}),
    .sync_out(lines_sync)
  );
  etw_sync #(.WIDTH(1), .RST_VAL(1'b0)) u_pwr_sync (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .async_in(power_good_in),
    .sync_out(pwr_good_s)
  );
  // straps are pins too, so they pass two flops
  etw_sync #(.WIDTH(3), .RST_VAL(3'h0)) u_strap_sync (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .async_in(strap_address_inputs_in),
    .sync_out(strap_s)
  );
  assign scl_s = lines_sync[1];
  assign sda_s = lines_sync[0];

  etw_edges u_edges (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .scl_in(scl_s),
    .sda_in(sda_s),
    .scl_rise_out(scl_rise),
    .scl_fall_out(scl_fall),
    .start_out(start_ev),
    .stop_out(stop_ev),
    .idle_out(idle_s)
  );

  etw_state_t state_ff;
  etw_state_t nxt_state;
  logic [3:0] bit_cnt_ff;
  logic [7:0] shift_ff;
  logic [7:0] tx_shift_ff;
  logic ack_drv_ff;
  logic rd_mode_ff;
  logic [2:0] strap_ff;
  logic [31:0] pup_cnt_ff;
  logic pup_done_ff;
  logic host_nack_ff;
  logic skip_fall_ff;

  function automatic logic addr_match(input logic [7:0] b,
                                      input logic [2:0] strap);
    addr_match = (b[7:4] == DEV_TYPE) && (b[3:1] == strap);
  endfunction

  // hold in reset until power good, then count wait
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in || !pwr_good_s) begin
      pup_cnt_ff <= '0;
      pup_done_ff <= 1'b0;
    end else if (!pup_done_ff) begin
      if (pup_cnt_ff == 32'(PUP_WAIT_CYC - 1)) begin
        pup_done_ff <= 1'b1;
      end
      pup_cnt_ff <= pup_cnt_ff + 32'h1;
    end
  end

  // Straps follow their synchronised pins; tied off in practice
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      strap_ff <= 3'h0;
    end else begin
      strap_ff <= strap_s;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ETW_ST_RESET: begin
        if (pwr_good_s) begin
          nxt_state = ETW_ST_STANDBY;
        end
      end
      ETW_ST_STANDBY: begin
        if (start_ev && !write_busy_in) begin
          nxt_state = ETW_ST_ADDR;
        end
      end
      ETW_ST_ADDR, ETW_ST_RX, ETW_ST_TX: begin
        if (stop_ev) begin
          nxt_state = ETW_ST_STANDBY;
        end else if (start_ev) begin
          nxt_state = ETW_ST_ADDR;
        end else if (scl_fall && bit_cnt_ff == 4'(ETW_ACK_BIT_IDX)) begin
          if (state_ff == ETW_ST_ADDR && !ack_drv_ff) begin
            nxt_state = ETW_ST_STANDBY;
          end else if (state_ff == ETW_ST_ADDR) begin
            nxt_state = rd_mode_ff ? ETW_ST_TX : ETW_ST_RX;
          end else if (state_ff == ETW_ST_TX && host_nack_ff) begin
            nxt_state = ETW_ST_STANDBY;
          end
        end
      end
      default: nxt_state = ETW_ST_RESET;
    endcase
    if (!pwr_good_s) begin
      nxt_state = ETW_ST_RESET;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      state_ff <= ETW_ST_RESET;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in || start_ev || stop_ev) begin
      bit_cnt_ff <= ETW_BIT_CNT_RST;
      shift_ff <= ETW_BYTE_RST;
    end else if (state_ff == ETW_ST_ADDR || state_ff == ETW_ST_RX ||
                 state_ff == ETW_ST_TX) begin
      if (scl_rise && bit_cnt_ff < 4'(ETW_BITS_PER_BYTE)) begin
        shift_ff <= {shift_ff[6:0], sda_s};
      end
      if (scl_fall && !skip_fall_ff) begin
        bit_cnt_ff <= (bit_cnt_ff == 4'(ETW_ACK_BIT_IDX)) ?
                      ETW_BIT_CNT_RST : bit_cnt_ff + 4'h1;
      end
    end
  end

  // the clock fall that closes a Start is not a bit clock
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      skip_fall_ff <= 1'b0;
    end else if (start_ev) begin
      skip_fall_ff <= 1'b1;
    end else if (scl_fall || stop_ev) begin
      skip_fall_ff <= 1'b0;
    end
  end

  // Host acknowledge on ninth rise during reads
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in || start_ev) begin
      host_nack_ff <= 1'b0;
    end else if (scl_rise && bit_cnt_ff == 4'(ETW_ACK_BIT_IDX)) begin
      host_nack_ff <= sda_s;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in || start_ev || stop_ev) begin
      ack_drv_ff <= 1'b0;
      rd_mode_ff <= 1'b0;
    end else if (scl_fall) begin
      if (bit_cnt_ff == 4'(ETW_BITS_PER_BYTE - 1)) begin
        if (state_ff == ETW_ST_ADDR) begin
          ack_drv_ff <= addr_match(shift_ff, strap_ff) && !write_busy_in;
          rd_mode_ff <= shift_ff[0];
        end else begin
          ack_drv_ff <= (state_ff == ETW_ST_RX);
        end
      end else if (bit_cnt_ff == 4'(ETW_ACK_BIT_IDX)) begin
        ack_drv_ff <= 1'b0;
      end
    end
  end

  // transmit shift, changed only after clock fall
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      tx_shift_ff <= 8'hFF;
    end else if (state_ff != ETW_ST_TX && nxt_state == ETW_ST_TX) begin
      tx_shift_ff <= tx_data_in;
    end else if (state_ff == ETW_ST_TX && scl_fall) begin
      if (bit_cnt_ff == 4'(ETW_ACK_BIT_IDX)) begin
        tx_shift_ff <= host_nack_ff ? 8'hFF : tx_data_in;
      end else begin
        tx_shift_ff <= {tx_shift_ff[6:0], 1'b1};
      end
    end else if (state_ff != ETW_ST_TX) begin
      tx_shift_ff <= 8'hFF;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      sda_out <= 1'b0;
      sda_oe_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
      if (ack_drv_ff && (state_ff == ETW_ST_ADDR ||
                         state_ff == ETW_ST_RX)) begin
        sda_oe_out <= 1'b1;
      end else if (state_ff == ETW_ST_TX &&
                   bit_cnt_ff < 4'(ETW_BITS_PER_BYTE)) begin
        sda_oe_out <= ~tx_shift_ff[7];
      end else begin
        sda_oe_out <= 1'b0;
      end
    end
  end

  // User-side strobes
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      rx_data_out <= ETW_BYTE_RST;
      rx_valid_out <= 1'b0;
      addr_byte_out <= ETW_BYTE_RST;
      addr_valid_out <= 1'b0;
      tx_req_out <= 1'b0;
      stop_seen_out <= 1'b0;
      standby_out <= 1'b0;
      ready_out <= 1'b0;
    end else begin
      rx_valid_out <= 1'b0;
      addr_valid_out <= 1'b0;
      tx_req_out <= 1'b0;
      stop_seen_out <= stop_ev && state_ff != ETW_ST_RESET;
      if (scl_fall && bit_cnt_ff == 4'(ETW_BITS_PER_BYTE - 1)) begin
        if (state_ff == ETW_ST_ADDR) begin
          addr_byte_out <= shift_ff;
          addr_valid_out <= addr_match(shift_ff, strap_ff) &&
                            !write_busy_in;
        end else if (state_ff == ETW_ST_RX) begin
          rx_data_out <= shift_ff;
          rx_valid_out <= 1'b1;
        end
      end
      if (state_ff == ETW_ST_TX && scl_fall &&
          bit_cnt_ff == 4'(ETW_ACK_BIT_IDX) && !host_nack_ff) begin
        tx_req_out <= 1'b1;
      end
      standby_out <= (state_ff == ETW_ST_STANDBY) && !write_busy_in;
      ready_out <= pup_done_ff && idle_s && !write_busy_in &&
                   !write_done_in;
    end
  end
endmodule
`default_nettype wire

// [etw_client_assertions.sv]
// Checker for the two-wire client: bus timing, acknowledge, standby.
// Assumes it is bound to etw_client and sees only that module's ports.
`timescale 1ns/1ns
`default_nettype none
module etw_client_assertions (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // Watched ports
  input wire logic power_good_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic write_busy_in,
  input wire logic sda_out,
  input wire logic sda_oe_out,
  input wire logic addr_valid_out,
  input wire logic stop_seen_out,
  input wire logic standby_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  sequence ack_drive;
    ##[1:6] sda_oe_out ##1 sda_oe_out [*3];
  endsequence
  a_open_drain: assert property (!sda_out)
    else $error("data pin driven high");
  a_unpowered_quiet: assert property (!power_good_in [*4] |->
    !sda_oe_out && !addr_valid_out)
    else $error("activity below power threshold");
  a_change_scl_low: assert property ($changed(sda_oe_out) |-> !scl_in)
    else $error("data changed while clock high");
  a_ack_stands: assert property ($rose(scl_in) && sda_oe_out |->
    sda_oe_out [*4])
    else $error("low level dropped in high phase");
  a_ack_on_match: assert property (addr_valid_out |-> ack_drive)
    else $error("matched address not acknowledged");
  a_busy_no_ack: assert property (addr_valid_out |-> !write_busy_in)
    else $error("address taken while write busy");
  a_stop_standby: assert property (stop_seen_out && !write_busy_in |->
    ##[0:3] standby_out)
    else $error("no standby after stop");
  a_stop_lines_high: assert property (stop_seen_out |->
    scl_in && sda_in)
    else $error("stop flagged with bus not idle");
  a_standby_quiet: assert property (standby_out |-> !sda_oe_out)
    else $error("data driven in standby");
endmodule
bind etw_client etw_client_assertions i_chk (
  .clk_sys_in(clk_sys_in),
  .sys_rst_in(sys_rst_in),
  .power_good_in(power_good_in),
  .scl_in(scl_in),
  .sda_in(sda_in),
  .write_busy_in(write_busy_in),
  .sda_out(sda_out),
  .sda_oe_out(sda_oe_out),
  .addr_valid_out(addr_valid_out),
  .stop_seen_out(stop_seen_out),
  .standby_out(standby_out)
);
`default_nettype wire

// [etw_host.sv]
// Host model: makes the serial clock and drives the data line low.
// Assumes the bench resolves the open-drain data line with a pull-up.
`timescale 1ns/1ns
`default_nettype none
module etw_host (
  // Bus lines
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_oe_out
);
  initial begin
    scl_out = 1'b1;
    sda_oe_out = 1'b0;
  end
  task automatic start_c();
    sda_oe_out = 1'b0;
    #31 scl_out = 1'b1;
    #62 sda_oe_out = 1'b1;
    #62 scl_out = 1'b0;
    #31;
  endtask
  task automatic stop_c();
    sda_oe_out = 1'b1;
    #31 scl_out = 1'b1;
    #62 sda_oe_out = 1'b0;
    #125;
  endtask
  task automatic xfer(input logic [7:0] d, input logic hb,
                      output logic [8:0] q);
    for (int i = 8; i >= 0; i--) begin
      sda_oe_out = (i > 0) ? !d[i-1] : !hb;
      #32 scl_out = 1'b1;
      #62 q[i] = sda_in;
      scl_out = 1'b0;
      #31;
    end
  endtask
  task automatic pulse();
    sda_oe_out = 1'b0;
    #32 scl_out = 1'b1;
    #62 scl_out = 1'b0;
    #31;
  endtask
endmodule
`default_nettype wire

// [etw_client_tb_top.sv]
// Testbench of the two-wire client with a host model on the bus.
// Assumes a 100 MHz system clock and a 125 ns serial clock.
`timescale 1ns/1ns
`default_nettype none
module etw_client_tb_top;
  import etw_pkg::*;
  `define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin \
    err_count++; $display("mismatch %s exp %h got %h", n, e, a); end end
  // Arbitrary device type for the bench
  localparam logic [3:0] TYPE_ID = 4'h6;
  localparam logic [2:0] STRAP = 3'h5;
  localparam logic [7:0] ADW = {TYPE_ID, STRAP, 1'b0};
  localparam logic [7:0] ADR = {TYPE_ID, STRAP, 1'b1};
  localparam logic [7:0] TXB = 8'hB4;
  logic clk_sys_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic power_good_in = 1'b0;
  logic write_busy_in = 1'b0;
  logic write_done_in = 1'b0;
  logic scl, h_oe, sda_out, sda_oe_out, tx_req_out, rx_valid_out;
  logic addr_valid_out, stop_seen_out, standby_out, ready_out;
  logic [7:0] rx_data_out, addr_byte_out, rx_q;
  logic [8:0] q;
  int err_count = 0;
  int checks_done = 0;
  int n_rx = 0;
  int n_txreq = 0;
  wire logic sda = !(h_oe || sda_oe_out);
  always #5 clk_sys_in = ~clk_sys_in;
  etw_host i_host (.sda_in(sda), .scl_out(scl), .sda_oe_out(h_oe));
  etw_client #(.PUP_WAIT_CYC(20), .DEV_TYPE(TYPE_ID)) i_dut (
    .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
    .power_good_in(power_good_in), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_out(sda_oe_out),
    .strap_address_inputs_in(STRAP), .write_busy_in(write_busy_in),
    .write_done_in(write_done_in), .tx_data_in(TXB),
    .tx_req_out(tx_req_out),
    .rx_data_out(rx_data_out), .rx_valid_out(rx_valid_out),
    .addr_byte_out(addr_byte_out), .addr_valid_out(addr_valid_out),
    .stop_seen_out(stop_seen_out), .standby_out(standby_out),
    .ready_out(ready_out));
  always @(posedge clk_sys_in) begin
    if (rx_valid_out) begin
      rx_q <= rx_data_out;
      n_rx <= n_rx + 1;
    end
    if (tx_req_out) begin
      n_txreq <= n_txreq + 1;
    end
  end
  task automatic report_and_stop();
    if (err_count == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic t_power();
    int k;
    i_host.start_c();
    i_host.xfer(ADW, 1'b1, q);
    `CHK("nack_unpowered", 1'b1, q[0])
    i_host.stop_c();
    @(posedge clk_sys_in);
    #1 power_good_in = 1'b1;
    k = 0;
    while (ready_out !== 1'b1 && k < 500) begin
      @(posedge clk_sys_in);
      k++;
    end
    `CHK("ready", 1'b1, ready_out)
    `CHK("standby", 1'b1, standby_out)
    if (k == 500) report_and_stop();
  endtask
  task automatic t_write();
    int n0;
    logic [7:0] d;
    n0 = n_rx;
    i_host.start_c();
    i_host.xfer(ADW, 1'b1, q);
    `CHK("addr_ack", 1'b0, q[0])
    `CHK("addr_byte", ADW, addr_byte_out)
    for (int i = 0; i < 3; i++) begin
      d = 8'h1D + 8'h61 * i[7:0];
      i_host.xfer(d, 1'b1, q);
      `CHK("data_ack", 1'b0, q[0])
      `CHK("rx_byte", d, rx_q)
    end
    i_host.stop_c();
    `CHK("rx_count", 3, n_rx - n0)
    `CHK("standby_stop", 1'b1, standby_out)
  endtask
  task automatic t_refuse();
    i_host.start_c();
    i_host.xfer({TYPE_ID, 3'h2, 1'b0}, 1'b1, q);
    `CHK("strap_nack", 1'b1, q[0])
    i_host.stop_c();
    @(posedge clk_sys_in);
    #1 write_busy_in = 1'b1;
    i_host.start_c();
    i_host.xfer(ADW, 1'b1, q);
    `CHK("busy_nack", 1'b1, q[0])
    i_host.stop_c();
    @(posedge clk_sys_in);
    #1 write_busy_in = 1'b0;
    write_done_in = 1'b1;
    @(posedge clk_sys_in);
    #1 write_done_in = 1'b0;
    `CHK("ready_done", 1'b0, ready_out)
    `CHK("standby_done", 1'b1, standby_out)
    i_host.start_c();
    i_host.xfer(ADW, 1'b1, q);
    `CHK("poll_ack", 1'b0, q[0])
    i_host.stop_c();
  endtask
  task automatic t_read();
    int n0;
    n0 = n_txreq;
    i_host.start_c();
    i_host.xfer(ADW, 1'b1, q);
    i_host.start_c();
    i_host.xfer(ADR, 1'b1, q);
    `CHK("restart_ack", 1'b0, q[0])
    i_host.xfer(8'hFF, 1'b0, q);
    `CHK("tx_first", TXB, q[8:1])
    i_host.xfer(8'hFF, 1'b1, q);
    `CHK("tx_second", TXB, q[8:1])
    `CHK("nack_free", 1'b1, q[0])
    i_host.stop_c();
    `CHK("standby_read", 1'b1, standby_out)
    `CHK("tx_req_count", 1, n_txreq - n0)
  endtask
  task automatic t_recover();
    int n;
    i_host.start_c();
    i_host.xfer(ADR, 1'b1, q);
    i_host.pulse();
    #40;
    `CHK("held_low", 1'b0, sda)
    n = 0;
    while (sda !== 1'b1 && n < 16) begin
      i_host.pulse();
      #40;
      n++;
    end
    `CHK("released", 1'b1, sda)
    `CHK("dummy_le9", 1'b1, n <= 9)
    if (n == 16) report_and_stop();
    i_host.start_c();
    i_host.xfer(ADW, 1'b1, q);
    `CHK("after_recover", 1'b0, q[0])
    i_host.stop_c();
  endtask
  initial begin
    repeat (16) @(posedge clk_sys_in);
    #1 sys_rst_in = 1'b0;
    t_power();
    t_write();
    t_refuse();
    t_read();
    t_recover();
    report_and_stop();
  end
endmodule
`default_nettype wire
